// *** rtl/psc_device.sv ***
`timescale 1ns/10ps
`include "psc_params.svh"
// How it works
// [RQ1] Reference is halved before phase comparison
// [RQ2] Loop divider divides oscillator by loop value
// [RQ3] Host keeps oscillator within 400-800 MHz
// [RQ4] Output divides by 1,2,4,8, 50% duty
// [RQ5] Parallel strobe rise captures loop, output selects
// [RQ6] Parallel path wins over serial path
// [RQ7] Serial shift register is fourteen bits
// [RQ8] One shift per serial clock rising edge
// [RQ9] Serial load fall latches when parallel high
// [RQ10] Test select chooses probe output node
// [RQ11] Host keeps serial clock at most 10 MHz
// [RQ12] Lock within ten milliseconds after configuration
// [RQ13] Loop value is plain unsigned binary
// [RQ14] Host holds parallel strobe low after power-up
// [RQ15] Undriven divider pins read as one
// [RQ16] Select codes: 11/1, 00/2, 01/4, 10/8
// [RQ17] Serial order test, output, loop; MSB first
// [RQ18] Parallel latches transparent while strobe low
// [RQ19] Test select forced zero while strobe low
// [RQ20] Serial load ignored while parallel strobe low
module psc_device #(
	parameter int LOCK_CYCLES = `PSC_LOCK_CYCLES
) (
	// System clock, twice the rate of the oscillator stand-in
	input wire logic SYS_CLK,
	input wire logic SRST,
	// Configuration pins
	psc_if.device LINK,
	// Reference input
	input wire logic EXTERNAL_REFERENCE_IN,
	// Synthesizer outputs
	output logic SYNTH_OUTPUT,
	output logic SYNTH_OUTPUT_N,
	output logic PROBE,
	output logic LOCKED,
	// Applied configuration
	output psc_pkg::psc_m_t LOOP_DIV,
	output psc_pkg::psc_ndiv_e OUT_DIV_SEL,
	output logic [2:0] TEST_SEL
);
	import psc_pkg::*;

	localparam logic [20:0] LOCK_LAST = 21'(LOCK_CYCLES - 1);

	psc_link_s l;
	psc_link_s next_l;
	psc_dev_s s;
	psc_dev_s next_s;

	// Link domain: runs only while the host toggles the serial clock
	always_comb begin
		next_l = l;
		next_l.rs1 = SRST;
		next_l.rs2 = l.rs1;
		if (l.rs2) begin
			next_l.sr = '0;
		end else begin
			next_l.sr = {l.sr[`PSC_SR_LEN-2:0], LINK.s_data}; // [RQ7] [RQ8] [RQ17]
		end
	end

	always_ff @(posedge LINK.s_clock) begin
		l <= next_l;
	end

	logic pl_rise;
	logic sl_fall;
	logic ref_rise;
	logic cfg_change;
	logic fb_wrap;

	always_comb begin
		next_s = s;
		pl_rise = s.pl_s2 & ~s.pl_q;
		sl_fall = ~s.sl_s2 & s.sl_q;
		ref_rise = s.ref_s2 & ~s.ref_q;
		fb_wrap = 1'b0;

		next_s.pl_s1 = LINK.p_load_n;
		next_s.pl_s2 = s.pl_s1;
		next_s.pl_q = s.pl_s2;
		next_s.sl_s1 = LINK.s_load;
		next_s.sl_s2 = s.sl_s1;
		next_s.sl_q = s.sl_s2;
		next_s.ref_s1 = EXTERNAL_REFERENCE_IN;
		next_s.ref_s2 = s.ref_s1;
		next_s.ref_q = s.ref_s2;
		next_s.m_s1 = LINK.m; // [RQ15]
		next_s.m_s2 = s.m_s1;
		next_s.n_s1 = LINK.n;
		next_s.n_s2 = s.n_s1;

		// Parallel side checked first so it always wins
		if (!s.pl_s2 || pl_rise) begin
			next_s.cfg_m = s.m_s2; // [RQ18] [RQ5] [RQ6] [RQ13]
			next_s.cfg_n = psc_ndiv_e'(s.n_s2); // [RQ5]
			if (!s.pl_s2) begin
				next_s.cfg_t = `PSC_T_QUIET; // [RQ19]
			end
		end else if (sl_fall) begin
			// Shift register is idle here: the host stops the serial
			// clock before the load strobe, so the word is stable
			next_s.cfg_m = l.sr[`PSC_M_HI:`PSC_M_LO]; // [RQ9] [RQ17]
			next_s.cfg_n = psc_ndiv_e'(l.sr[`PSC_N_HI:`PSC_N_LO]);
			next_s.cfg_t = l.sr[`PSC_T_HI:`PSC_T_LO];
		end // [RQ20]

		if (ref_rise) begin
			next_s.ref_half = ~s.ref_half; // [RQ1]
		end

		// Oscillator stand-in: bit 0 of a free count
		next_s.vco_cnt = s.vco_cnt + 4'h1;
		if (s.vco_cnt[0]) begin
			if (s.fb_cnt >= s.cfg_m - 7'h1) begin
				next_s.fb_cnt = '0;
				fb_wrap = 1'b1;
			end else begin
				next_s.fb_cnt = s.fb_cnt + 7'h1; // [RQ2]
			end
		end
		if (fb_wrap) begin
			next_s.fb_half = ~s.fb_half; // [RQ2]
		end

		// Count bits give exact 50% duty at every ratio
		case (s.cfg_n)
			PSC_DIV1: next_s.synth = s.vco_cnt[0]; // [RQ4] [RQ16]
			PSC_DIV2: next_s.synth = s.vco_cnt[1];
			PSC_DIV4: next_s.synth = s.vco_cnt[2];
			PSC_DIV8: next_s.synth = s.vco_cnt[3];
			default: next_s.synth = s.vco_cnt[0];
		endcase

		// Out-of-span loop values never report lock
		cfg_change = (next_s.cfg_m != s.cfg_m) || (next_s.cfg_n != s.cfg_n);
		if (cfg_change) begin
			next_s.lock_cnt = '0;
			next_s.locked = 1'b0;
		end else if (s.lock_cnt == LOCK_LAST) begin
			next_s.locked = (s.cfg_m >= `PSC_M_MIN) && (s.cfg_m <= `PSC_M_MAX); // [RQ12] [RQ3]
		end else begin
			next_s.lock_cnt = s.lock_cnt + 21'h1; // [RQ12]
		end

		case (s.cfg_t)
			3'h0: next_s.probe = 1'b0; // [RQ10]
			3'h1: next_s.probe = s.ref_half;
			3'h2: next_s.probe = s.fb_half;
			3'h3: next_s.probe = s.vco_cnt[0];
			3'h4: next_s.probe = s.synth;
			3'h5: next_s.probe = s.locked;
			3'h6: next_s.probe = s.sl_s2;
			3'h7: next_s.probe = 1'b1;
			default: next_s.probe = 1'b0;
		endcase

		if (SRST) begin
			next_s = '0;
			next_s.pl_s1 = 1'b1;
			next_s.pl_s2 = 1'b1;
			next_s.pl_q = 1'b1;
			next_s.cfg_m = `PSC_M_MIN;
			next_s.cfg_n = PSC_DIV1;
		end
	end

	always_ff @(posedge SYS_CLK) begin
		s <= next_s;
	end

	assign SYNTH_OUTPUT = s.synth;
	assign SYNTH_OUTPUT_N = ~s.synth;
	assign PROBE = s.probe;
	assign LOCKED = s.locked;
	assign LOOP_DIV = s.cfg_m;
	assign OUT_DIV_SEL = s.cfg_n;
	assign TEST_SEL = s.cfg_t;
endmodule

// *** rtl/psc_params.svh ***
`ifndef PSC_PARAMS_SVH
`define PSC_PARAMS_SVH
`define PSC_SYS_PERIOD_NS 5
`define PSC_SYS_MHZ 200
`define PSC_SR_LEN 14
`define PSC_T_HI 13
`define PSC_T_LO 11
`define PSC_N_HI 10
`define PSC_N_LO 9
`define PSC_M_HI 6
`define PSC_M_LO 0
`define PSC_M_WIDTH 7
`define PSC_M_MIN 7'h19
`define PSC_M_MAX 7'h32
`define PSC_T_QUIET 3'h0
`define PSC_LOCK_MS 10
`define PSC_LOCK_CYCLES (`PSC_LOCK_MS * `PSC_SYS_MHZ * 1000)
`define PSC_SCLK_HALF_NS 50
`define PSC_SCLK_HALF_CYC ((`PSC_SCLK_HALF_NS + `PSC_SYS_PERIOD_NS - 1) / `PSC_SYS_PERIOD_NS)
`define PSC_PW_NS 60
`define PSC_PW_CYC ((`PSC_PW_NS + `PSC_SYS_PERIOD_NS - 1) / `PSC_SYS_PERIOD_NS)
`define PSC_HOLD_NS 40
`define PSC_HOLD_CYC ((`PSC_HOLD_NS + `PSC_SYS_PERIOD_NS - 1) / `PSC_SYS_PERIOD_NS)
`define PSC_PWRUP_NS 2000
`define PSC_PWRUP_CYC ((`PSC_PWRUP_NS + `PSC_SYS_PERIOD_NS - 1) / `PSC_SYS_PERIOD_NS)
`endif

// *** rtl/psc_pkg.sv ***
package psc_pkg;
	typedef enum logic [1:0] {
		PSC_DIV2 = 2'b00,
		PSC_DIV4 = 2'b01,
		PSC_DIV8 = 2'b10,
		PSC_DIV1 = 2'b11
	} psc_ndiv_e;

	typedef logic [6:0] psc_m_t;
	typedef logic [13:0] psc_sr_t;

	typedef enum logic [2:0] {
		PSC_H_PWRUP = 3'b000,
		PSC_H_PHOLD = 3'b001,
		PSC_H_IDLE = 3'b010,
		PSC_H_PLOW = 3'b011,
		PSC_H_SHIFT = 3'b100,
		PSC_H_SSET = 3'b101,
		PSC_H_SLOAD = 3'b110,
		PSC_H_SHOLD = 3'b111
	} psc_hstate_e;

	typedef struct packed {
		logic rs1;
		logic rs2;
		psc_sr_t sr;
	} psc_link_s;

	typedef struct packed {
		logic pl_s1;
		logic pl_s2;
		logic pl_q;
		logic sl_s1;
		logic sl_s2;
		logic sl_q;
		logic ref_s1;
		logic ref_s2;
		logic ref_q;
		psc_m_t m_s1;
		psc_m_t m_s2;
		logic [1:0] n_s1;
		logic [1:0] n_s2;
		psc_m_t cfg_m;
		psc_ndiv_e cfg_n;
		logic [2:0] cfg_t;
		logic ref_half;
		logic [3:0] vco_cnt;
		psc_m_t fb_cnt;
		logic fb_half;
		logic [20:0] lock_cnt;
		logic locked;
		logic synth;
		logic probe;
	} psc_dev_s;

	typedef struct packed {
		psc_hstate_e st;
		logic [15:0] cnt;
		logic [3:0] bits;
		psc_sr_t sr;
		logic sclk;
		logic sdata;
		logic sload;
		logic pload_n;
		logic drive;
		psc_m_t m;
		logic [1:0] n;
	} psc_host_s;
endpackage

// *** rtl/psc_if.sv ***
`timescale 1ns/10ps
interface psc_if;
	logic [6:0] m_o;
	logic m_oe;
	logic [1:0] n_o;
	logic n_oe;
	logic [6:0] m;
	logic [1:0] n;
	logic p_load_n;
	logic s_clock;
	logic s_data;
	logic s_load;

	// Pull-ups: undriven divider pins read as ones
	assign m = m_oe ? m_o : 7'h7F;
	assign n = n_oe ? n_o : 2'h3;

	modport device (input m, input n, input p_load_n, input s_clock, input s_data, input s_load);
	modport host (output m_o, output m_oe, output n_o, output n_oe, output p_load_n,
		output s_clock, output s_data, output s_load);
endinterface

// *** rtl/psc_host.sv ***
`timescale 1ns/10ps
`include "psc_params.svh"
module psc_host #(
	parameter int PWRUP_CYCLES = `PSC_PWRUP_CYC
) (
	// Clock and reset
	input wire logic SYS_CLK,
	input wire logic SRST,
	// Power-up configuration
	input psc_pkg::psc_m_t INIT_LOOP_DIV,
	input wire logic [1:0] INIT_OUT_DIV,
	// Command port
	input wire logic CMD_VALID,
	output logic CMD_READY,
	input wire logic CMD_SERIAL,
	input psc_pkg::psc_m_t CMD_LOOP_DIV,
	input wire logic [1:0] CMD_OUT_DIV,
	input wire logic [2:0] CMD_TEST_SEL,
	// Pins toward the synthesizer
	psc_if.host LINK
);
	import psc_pkg::*;

	localparam logic [15:0] HALF = 16'(`PSC_SCLK_HALF_CYC - 1);
	localparam logic [15:0] PW = 16'(`PSC_PW_CYC - 1);
	localparam logic [15:0] HOLD = 16'(`PSC_HOLD_CYC - 1);
	localparam logic [15:0] PWRUP = 16'(PWRUP_CYCLES - 1);

	psc_host_s h;
	psc_host_s next_h;

	always_comb begin
		next_h = h;
		next_h.cnt = h.cnt + 16'h1;
		case (h.st)
			PSC_H_PWRUP: begin
				// Strobe low through power-up, then released
				if (h.cnt == PWRUP) begin // [RQ14]
					next_h.pload_n = 1'b1;
					next_h.st = PSC_H_PHOLD;
					next_h.cnt = '0;
				end
			end
			PSC_H_PLOW: begin
				if (h.cnt == PW) begin
					next_h.pload_n = 1'b1; // [RQ5]
					next_h.st = PSC_H_PHOLD;
					next_h.cnt = '0;
				end
			end
			PSC_H_PHOLD: begin
				if (h.cnt == HOLD) begin
					next_h.drive = 1'b0;
					next_h.st = PSC_H_IDLE;
				end
			end
			PSC_H_IDLE: begin
				next_h.cnt = '0;
				if (CMD_VALID && CMD_SERIAL) begin
					next_h.sr = {CMD_TEST_SEL, CMD_OUT_DIV, 2'b00, CMD_LOOP_DIV}; // [RQ17]
					next_h.sdata = CMD_TEST_SEL[2];
					next_h.bits = '0;
					next_h.st = PSC_H_SHIFT;
				end else if (CMD_VALID) begin
					next_h.m = CMD_LOOP_DIV;
					next_h.n = CMD_OUT_DIV;
					next_h.drive = 1'b1;
					next_h.pload_n = 1'b0;
					next_h.st = PSC_H_PLOW;
				end
			end
			PSC_H_SHIFT: begin
				// Divided clock: 50 ns halves keep it at 10 MHz
				if (h.cnt == HALF) begin // [RQ11]
					next_h.cnt = '0;
					next_h.sclk = ~h.sclk;
					if (h.sclk) begin
						next_h.sr = {h.sr[`PSC_SR_LEN-2:0], 1'b0};
						next_h.sdata = h.sr[`PSC_SR_LEN-2];
						next_h.bits = h.bits + 4'h1;
						if (h.bits == 4'(`PSC_SR_LEN - 1)) begin
							next_h.st = PSC_H_SSET;
						end
					end
				end
			end
			PSC_H_SSET: begin
				if (h.cnt == HOLD) begin
					next_h.sload = 1'b1;
					next_h.st = PSC_H_SLOAD;
					next_h.cnt = '0;
				end
			end
			PSC_H_SLOAD: begin
				if (h.cnt == PW) begin
					next_h.sload = 1'b0; // [RQ9]
					next_h.st = PSC_H_SHOLD;
					next_h.cnt = '0;
				end
			end
			PSC_H_SHOLD: begin
				if (h.cnt == HOLD) begin
					next_h.st = PSC_H_IDLE;
				end
			end
			default: next_h.st = PSC_H_IDLE;
		endcase
		if (SRST) begin
			next_h = '0;
			next_h.st = PSC_H_PWRUP;
			next_h.m = INIT_LOOP_DIV;
			next_h.n = INIT_OUT_DIV;
			next_h.drive = 1'b1;
		end
	end

	always_ff @(posedge SYS_CLK) begin
		h <= next_h;
	end

	assign CMD_READY = (h.st == PSC_H_IDLE);
	assign LINK.m_o = h.m;
	assign LINK.m_oe = h.drive;
	assign LINK.n_o = h.n;
	assign LINK.n_oe = h.drive;
	assign LINK.p_load_n = h.pload_n;
	assign LINK.s_clock = h.sclk;
	assign LINK.s_data = h.sdata;
	assign LINK.s_load = h.sload;
endmodule

// *** sim/psc_link_props.sv ***
`timescale 1ns/10ps
module psc_link_props (
	// Clock and reset
	input wire logic SYS_CLK,
	input wire logic SRST,
	// Link pins
	input wire logic [6:0] m,
	input wire logic [1:0] n,
	input wire logic m_oe,
	input wire logic n_oe,
	input wire logic p_load_n,
	input wire logic s_clock,
	input wire logic s_data,
	input wire logic s_load
);
	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (SRST);

	m_pullup_a: assert property (!m_oe |-> m == 7'h7F) else $error("m not pulled up");
	n_pullup_a: assert property (!n_oe |-> n == 2'h3) else $error("n not pulled up");
	sclk_rate_a: assert property ($changed(s_clock) |=> $stable(s_clock) [*8])
		else $error("serial clock too fast");
	sdata_hold_a: assert property ($rose(s_clock) |-> $stable(s_data) [*5])
		else $error("serial data moved at clock rise");
	pload_width_a: assert property ($fell(p_load_n) |=> !p_load_n [*8])
		else $error("parallel strobe too short");
	mn_hold_a: assert property ($rose(p_load_n) |-> ($stable(m) && $stable(n)) [*4])
		else $error("divider pins moved at capture");
	sload_width_a: assert property ($rose(s_load) |=> s_load [*8])
		else $error("serial load too short");
	sload_quiet_a: assert property (s_load |-> !s_clock && p_load_n)
		else $error("serial load overlaps clock or parallel strobe");
	sclk_idle_a: assert property (!p_load_n |-> !s_clock)
		else $error("shifting during parallel load");

	cover property ($fell(s_load));
	cover property ($rose(p_load_n));
	cover property ($rose(s_clock));
endmodule

// *** sim/tb_top.sv ***
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin errors++; \
	$display("CHECK FAILED %s exp %0h got %0h", nm, ex, got); end end
module tb_top;
	import psc_pkg::*;
	logic SYS_CLK = 0;
	logic SRST = 1;
	logic ref_in = 0;
	logic CMD_VALID = 0;
	logic CMD_READY;
	logic CMD_SERIAL = 0;
	psc_m_t CMD_LOOP_DIV = 7'h00;
	logic [1:0] CMD_OUT_DIV = 2'h0;
	logic [2:0] CMD_TEST_SEL = 3'h0;
	logic synth, synth_n, probe, locked;
	psc_m_t loop_div;
	psc_ndiv_e out_sel;
	logic [2:0] test_sel;
	int errors = 0;
	int checks = 0;
	int sclk_rises = 0;
	int r, h, s0;
	int divs[4] = '{2, 4, 8, 1};

	always #2.5 SYS_CLK = ~SYS_CLK;
	// Reference unrelated to the system clock, so the sampled ratio jitters
	always #31.25 ref_in = ~ref_in;

	psc_if link();
	psc_host #(.PWRUP_CYCLES(20)) u_psc_host (.SYS_CLK(SYS_CLK), .SRST(SRST),
		.INIT_LOOP_DIV(7'h20), .INIT_OUT_DIV(2'h1), .CMD_VALID(CMD_VALID),
		.CMD_READY(CMD_READY), .CMD_SERIAL(CMD_SERIAL), .CMD_LOOP_DIV(CMD_LOOP_DIV),
		.CMD_OUT_DIV(CMD_OUT_DIV), .CMD_TEST_SEL(CMD_TEST_SEL), .LINK(link));
	psc_device #(.LOCK_CYCLES(50)) u_psc_device (.SYS_CLK(SYS_CLK), .SRST(SRST),
		.LINK(link), .EXTERNAL_REFERENCE_IN(ref_in), .SYNTH_OUTPUT(synth),
		.SYNTH_OUTPUT_N(synth_n), .PROBE(probe), .LOCKED(locked), .LOOP_DIV(loop_div),
		.OUT_DIV_SEL(out_sel), .TEST_SEL(test_sel));
	psc_link_props u_props (.SYS_CLK(SYS_CLK), .SRST(SRST), .m(link.m), .n(link.n),
		.m_oe(link.m_oe), .n_oe(link.n_oe), .p_load_n(link.p_load_n),
		.s_clock(link.s_clock), .s_data(link.s_data), .s_load(link.s_load));

	always @(posedge link.s_clock) sclk_rises++;

	task automatic wait_ready();
		int k;
		k = 0;
		do begin
			@(posedge SYS_CLK);
			k++;
		end while (CMD_READY !== 1'b1 && k < 1000);
	endtask

	task automatic cmd(input bit ser, input psc_m_t m, input logic [1:0] n, input logic [2:0] t);
		wait_ready();
		CMD_SERIAL <= ser;
		CMD_LOOP_DIV <= m;
		CMD_OUT_DIV <= n;
		CMD_TEST_SEL <= t;
		CMD_VALID <= 1'b1;
		@(posedge SYS_CLK);
		CMD_VALID <= 1'b0;
		wait_ready();
		repeat (6) @(posedge SYS_CLK);
	endtask

	// Rising edges and high cycles of synth (sel 0) or probe over n cycles
	task automatic measure(input bit sel, input int n);
		logic prev;
		r = 0;
		h = 0;
		prev = sel ? probe : synth;
		repeat (n) begin
			// Falling edge: outputs launched at the rising edge have settled
			@(negedge SYS_CLK);
			if ((sel ? probe : synth) === 1'b1) h++;
			if (prev === 1'b0 && (sel ? probe : synth) === 1'b1) r++;
			prev = sel ? probe : synth;
			if (!sel) `CHK("synth_n", ~synth, synth_n)
		end
	endtask

	task automatic t_powerup();
		wait_ready();
		`CHK("pwr_m", 7'h20, loop_div)
		`CHK("pwr_n", PSC_DIV4, out_sel)
		`CHK("pwr_t", 3'h0, test_sel)
		$display("done powerup");
	endtask

	task automatic t_parallel();
		fork
			cmd(1'b0, 7'h32, 2'h0, 3'h5);
			begin
				wait (link.p_load_n === 1'b0);
				repeat (8) @(posedge SYS_CLK);
				`CHK("transp_m", 7'h32, loop_div)
			end
		join
		`CHK("par_n", PSC_DIV2, out_sel)
		`CHK("par_t", 3'h0, test_sel)
		repeat (60) @(posedge SYS_CLK);
		`CHK("lock50", 1'b1, locked)
		$display("done parallel");
	endtask

	task automatic t_outdiv();
		for (int i = 0; i < 4; i++) begin
			s0 = sclk_rises;
			cmd(1'b1, 7'h19, 2'(i), 3'h4);
			`CHK("shifts", 14, sclk_rises - s0)
			`CHK("ser_m", 7'h19, loop_div)
			`CHK("ser_n", psc_ndiv_e'(i), out_sel)
			`CHK("ser_t", 3'h4, test_sel)
			measure(1'b0, 64);
			`CHK("rises", 32 / divs[i], r)
			`CHK("duty", 32, h)
		end
		$display("done outdiv");
	endtask

	task automatic t_probe();
		cmd(1'b1, 7'h19, 2'h3, 3'h2);
		measure(1'b1, 400);
		`CHK("fb_rises", 4, r)
		cmd(1'b1, 7'h19, 2'h3, 3'h1);
		measure(1'b1, 250);
		`CHK("ref_rises", 1'b1, (r >= 9 && r <= 11))
		cmd(1'b1, 7'h19, 2'h3, 3'h7);
		`CHK("probe_one", 1'b1, probe)
		cmd(1'b1, 7'h19, 2'h3, 3'h5);
		`CHK("probe_lock", 1'b1, probe)
		cmd(1'b1, 7'h19, 2'h3, 3'h3);
		measure(1'b1, 250);
		`CHK("osc_rises", 125, r)
		cmd(1'b1, 7'h19, 2'h3, 3'h0);
		`CHK("probe_quiet", 1'b0, probe)
		$display("done probe");
	endtask

	task automatic t_nolock();
		cmd(1'b0, 7'h3C, 2'h3, 3'h0);
		repeat (100) @(posedge SYS_CLK);
		`CHK("nolock", 1'b0, locked)
		`CHK("pullup", 7'h7F, link.m)
		$display("done nolock");
	endtask

	task automatic tally_and_finish();
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	initial begin
		repeat (12) @(posedge SYS_CLK);
		SRST <= 1'b0;
		t_powerup();
		t_parallel();
		t_outdiv();
		t_probe();
		t_nolock();
		tally_and_finish();
	end

	// Whole run needs well under ten thousand cycles
	initial begin
		repeat (40000) @(posedge SYS_CLK);
		errors++;
		tally_and_finish();
	end
endmodule
